//--- nvh_host.v
// Host controller driving an asynchronous non-volatile static memory over its pins
`timescale 1ns/1ps
`include "nvh_consts.vh"

module nvh_host #(
  parameter ADDR_W       = 18,
  parameter SLOW_GRADE   = 0,
  parameter POWERUP_CYC  = `NVH_POWERUP_RESTORE_MS * 1000000 / `NVH_CLK_PERIOD_NS,
  parameter CMD_PROC_CYC = `NVH_CMD_PROC_US * 1000 / `NVH_CLK_PERIOD_NS,
  parameter SAVE_CYC     = `NVH_SAVE_TIME_MS * 1000000 / `NVH_CLK_PERIOD_NS,
  parameter RESTORE_CYC  = `NVH_RESTORE_TIME_US * 1000 / `NVH_CLK_PERIOD_NS,
  parameter [17:0] SEQ_ADDR_0       = 18'h00001,
  parameter [17:0] SEQ_ADDR_1       = 18'h00002,
  parameter [17:0] SEQ_ADDR_2       = 18'h00003,
  parameter [17:0] SEQ_ADDR_3       = 18'h00004,
  parameter [17:0] SEQ_ADDR_4       = 18'h00005,
  parameter [17:0] SEQ_SAVE_ADDR    = 18'h00006,
  parameter [17:0] SEQ_RESTORE_ADDR = 18'h00007
) (
  input  wire              SYS_CLK,
  input  wire              SRST,
  input  wire              CMD_VALID,
  input  wire [2:0]        CMD_OP,
  input  wire [ADDR_W-1:0] CMD_ADDR,
  input  wire [15:0]       CMD_WDATA,
  input  wire [1:0]        CMD_BYTE_EN,
  output reg               CMD_READY,
  output reg               RSP_VALID,
  output reg  [15:0]       RSP_RDATA,
  output reg               RSP_SUSPECT,
  output reg  [ADDR_W-1:0] MEM_ADDR,
  output reg               CHIP_SEL_N,
  output reg               WRITE_STROBE_N,
  output reg               OUTPUT_DRIVE_N,
  output reg               UPPER_BYTE_SEL_N,
  output reg               LOWER_BYTE_SEL_N,
  input  wire [15:0]       DQ_IN,
  output reg  [15:0]       DQ_OUT,
  output reg               DQ_OE,
  input  wire              STORE_BUSY_N_IN,
  output reg               STORE_BUSY_N_OUT,
  output reg               STORE_BUSY_N_OE
);

  localparam T_RC_NS  = SLOW_GRADE ? `NVH_T_RC_SLOW_NS : `NVH_T_RC_FAST_NS;
  localparam RC_CYC   = (T_RC_NS + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS;
  localparam PULSE_CYC = (`NVH_SAVE_REQ_PULSE_NS + `NVH_CLK_PERIOD_NS - 1)
                         / `NVH_CLK_PERIOD_NS;
  localparam SETTLE_CYC = (`NVH_BUSY_SETTLE_NS + `NVH_CLK_PERIOD_NS - 1)
                          / `NVH_CLK_PERIOD_NS + `NVH_SYNC_STAGES;

  localparam [31:0] RD_SUM      = RC_CYC + `NVH_SYNC_STAGES;
  localparam [31:0] WR_SUM      = RC_CYC;
  localparam [31:0] PULSE_SUM   = PULSE_CYC;
  localparam [31:0] SETTLE_SUM  = SETTLE_CYC;
  localparam [31:0] PU_SUM      = POWERUP_CYC;
  localparam [31:0] SW_SAVE_SUM = CMD_PROC_CYC + SAVE_CYC;
  localparam [31:0] SW_REST_SUM = CMD_PROC_CYC + RESTORE_CYC;
  localparam [31:0] SEQ_SUM     = `NVH_SEQ_LEN - 1;

  localparam [22:0] RD_LEN      = RD_SUM[22:0];
  localparam [22:0] WR_LEN      = WR_SUM[22:0];
  localparam [22:0] PULSE_LEN   = PULSE_SUM[22:0];
  localparam [22:0] SETTLE_LEN  = SETTLE_SUM[22:0];
  localparam [22:0] PU_LEN      = PU_SUM[22:0];
  localparam [22:0] SW_SAVE_LEN = SW_SAVE_SUM[22:0];
  localparam [22:0] SW_REST_LEN = SW_REST_SUM[22:0];
  localparam [2:0]  SEQ_LAST    = SEQ_SUM[2:0];

  localparam [8:0] S_POWERUP = 9'h001;
  localparam [8:0] S_IDLE    = 9'h002;
  localparam [8:0] S_SETUP   = 9'h004;
  localparam [8:0] S_READ    = 9'h008;
  localparam [8:0] S_WRITE   = 9'h010;
  localparam [8:0] S_RECOV   = 9'h020;
  localparam [8:0] S_PULSE   = 9'h040;
  localparam [8:0] S_BUSYWT  = 9'h080;
  localparam [8:0] S_SWWAIT  = 9'h100;

  reg [8:0]        state;
  reg [22:0]       count;
  reg [2:0]        op;
  reg [1:0]        byte_en;
  reg [2:0]        seq_idx;
  reg [15:0]       dq_meta;
  reg [15:0]       dq_sync;
  reg              busy_meta;
  reg              busy_sync;
  reg [ADDR_W-1:0] seq_addr;

  wire seq_op = (op == `NVH_OP_SW_SAVE) || (op == `NVH_OP_SW_RESTORE);

  // Fixed address order of the command sequence
  always @* begin
    case (seq_idx)
      3'h0:    seq_addr = SEQ_ADDR_0[ADDR_W-1:0];
      3'h1:    seq_addr = SEQ_ADDR_1[ADDR_W-1:0];
      3'h2:    seq_addr = SEQ_ADDR_2[ADDR_W-1:0];
      3'h3:    seq_addr = SEQ_ADDR_3[ADDR_W-1:0];
      3'h4:    seq_addr = SEQ_ADDR_4[ADDR_W-1:0];
      default: seq_addr = (op == `NVH_OP_SW_SAVE) ? SEQ_SAVE_ADDR[ADDR_W-1:0]
                                                  : SEQ_RESTORE_ADDR[ADDR_W-1:0];
    endcase
  end

  // Pin input synchronisers
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      dq_meta   <= 16'h0000;
      dq_sync   <= 16'h0000;
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end else begin
      dq_meta   <= DQ_IN;
      dq_sync   <= dq_meta;
      busy_meta <= STORE_BUSY_N_IN;
      busy_sync <= busy_meta;
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state            <= S_POWERUP;
      count            <= PU_LEN;
      op               <= `NVH_OP_READ;
      byte_en          <= 2'h0;
      seq_idx          <= 3'h0;
      CMD_READY        <= 1'b0;
      RSP_VALID        <= 1'b0;
      RSP_RDATA        <= 16'h0000;
      RSP_SUSPECT      <= 1'b0;
      MEM_ADDR         <= {ADDR_W{1'b0}};
      CHIP_SEL_N       <= 1'b1;
      WRITE_STROBE_N   <= 1'b1;
      OUTPUT_DRIVE_N   <= 1'b1;
      UPPER_BYTE_SEL_N <= 1'b1;
      LOWER_BYTE_SEL_N <= 1'b1;
      DQ_OUT           <= 16'h0000;
      DQ_OE            <= 1'b0;
      STORE_BUSY_N_OUT <= 1'b1;
      STORE_BUSY_N_OE  <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state)
        S_POWERUP: begin
          // Device restores from non-volatile array first
          if (count <= 23'h000001) begin
            state     <= S_BUSYWT;
            count     <= SETTLE_LEN;
          end else begin
            count <= count - 23'h000001;
          end
        end
        S_IDLE: begin
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            op        <= CMD_OP;
            byte_en   <= CMD_BYTE_EN;
            seq_idx   <= 3'h0;
            DQ_OUT    <= CMD_WDATA;
            if (CMD_OP == `NVH_OP_HW_SAVE) begin
              state            <= S_PULSE;
              count            <= PULSE_LEN;
              STORE_BUSY_N_OUT <= 1'b0;
              STORE_BUSY_N_OE  <= 1'b1;
            end else begin
              state    <= S_SETUP;
              MEM_ADDR <= CMD_ADDR;
              if (CMD_OP == `NVH_OP_SW_SAVE || CMD_OP == `NVH_OP_SW_RESTORE) begin
                byte_en <= 2'h3;
              end
            end
          end else begin
            CMD_READY <= busy_sync;
          end
        end
        S_SETUP: begin
          if (seq_op) begin
            MEM_ADDR <= seq_addr;
          end
          CHIP_SEL_N       <= 1'b0;
          UPPER_BYTE_SEL_N <= ~byte_en[1];
          LOWER_BYTE_SEL_N <= ~byte_en[0];
          if (op == `NVH_OP_WRITE) begin
            state          <= S_WRITE;
            count          <= WR_LEN;
            WRITE_STROBE_N <= 1'b0;
            DQ_OE          <= 1'b1;
          end else begin
            state          <= S_READ;
            count          <= RD_LEN;
            WRITE_STROBE_N <= 1'b1;
            OUTPUT_DRIVE_N <= 1'b0;
          end
        end
        S_READ: begin
          if (count <= 23'h000001) begin
            state          <= S_RECOV;
            CHIP_SEL_N     <= 1'b1;
            OUTPUT_DRIVE_N <= 1'b1;
            if (!seq_op) begin
              RSP_VALID   <= 1'b1;
              RSP_RDATA   <= dq_sync;
              RSP_SUSPECT <= 1'b0;
            end
          end else begin
            count <= count - 23'h000001;
          end
        end
        S_WRITE: begin
          if (count <= 23'h000001) begin
            state          <= S_RECOV;
            CHIP_SEL_N     <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
          end else begin
            count <= count - 23'h000001;
          end
        end
        S_RECOV: begin
          DQ_OE            <= 1'b0;
          UPPER_BYTE_SEL_N <= 1'b1;
          LOWER_BYTE_SEL_N <= 1'b1;
          if (seq_op && seq_idx != SEQ_LAST) begin
            seq_idx <= seq_idx + 3'h1;
            state   <= S_SETUP;
          end else if (seq_op) begin
            state <= S_SWWAIT;
            count <= (op == `NVH_OP_SW_SAVE) ? SW_SAVE_LEN : SW_REST_LEN;
          end else begin
            state     <= S_IDLE;
            CMD_READY <= busy_sync;
          end
        end
        S_PULSE: begin
          if (count <= 23'h000001) begin
            state            <= S_BUSYWT;
            count            <= SETTLE_LEN;
            STORE_BUSY_N_OUT <= 1'b1;
            STORE_BUSY_N_OE  <= 1'b0;
          end else begin
            count <= count - 23'h000001;
          end
        end
        S_BUSYWT: begin
          // Hold off while the device pulls busy low
          if (count != 23'h000000) begin
            count <= count - 23'h000001;
          end else if (busy_sync) begin
            state <= S_IDLE;
            if (op == `NVH_OP_HW_SAVE) begin
              RSP_VALID   <= 1'b1;
              RSP_SUSPECT <= 1'b0;
            end
          end
        end
        S_SWWAIT: begin
          if (count <= 23'h000001) begin
            state       <= S_BUSYWT;
            count       <= SETTLE_LEN;
            RSP_VALID   <= 1'b1;
            RSP_RDATA   <= dq_sync;
            RSP_SUSPECT <= 1'b1;
          end else begin
            count <= count - 23'h000001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // nvh_host

//--- nvh_consts.vh
// Timing and encoding constants for the static memory port host controller
`ifndef NVH_CONSTS_VH
`define NVH_CONSTS_VH

`define NVH_CLK_PERIOD_NS      5
`define NVH_T_RC_FAST_NS       25
`define NVH_T_RC_SLOW_NS       45
`define NVH_SAVE_REQ_PULSE_NS  15
`define NVH_BUSY_SETTLE_NS     25
`define NVH_POWERUP_RESTORE_MS 20
`define NVH_CMD_PROC_US        100
`define NVH_SAVE_TIME_MS       8
`define NVH_RESTORE_TIME_US    200
`define NVH_SYNC_STAGES        2
`define NVH_SEQ_LEN            6

`define NVH_OP_READ            3'h0
`define NVH_OP_WRITE           3'h1
`define NVH_OP_SW_SAVE         3'h2
`define NVH_OP_SW_RESTORE      3'h3
`define NVH_OP_HW_SAVE         3'h4

`endif

//--- nvh_host_checker.sv
// Pin timing checker for the memory port host
`timescale 1ns/1ps
module nvh_host_checker #(
  parameter ADDR_W = 18
) (
  input wire              SYS_CLK,
  input wire              SRST,
  input wire              CMD_READY,
  input wire [ADDR_W-1:0] MEM_ADDR,
  input wire              CHIP_SEL_N,
  input wire              WRITE_STROBE_N,
  input wire              OUTPUT_DRIVE_N,
  input wire              DQ_OE,
  input wire              STORE_BUSY_N_IN,
  input wire              STORE_BUSY_N_OUT,
  input wire              STORE_BUSY_N_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  a_read_we_high: assert property (!CHIP_SEL_N && !OUTPUT_DRIVE_N |-> WRITE_STROBE_N)
    else $error("write strobe low in read");
  a_no_save_cycle: assert property (!CHIP_SEL_N |-> !STORE_BUSY_N_OE)
    else $error("save request in memory cycle");
  a_addr_held: assert property (!CHIP_SEL_N && !$past(CHIP_SEL_N) |-> $stable(MEM_ADDR))
    else $error("address moved while selected");
  a_cycle_len: assert property ($fell(CHIP_SEL_N) |-> !CHIP_SEL_N [*5])
    else $error("memory cycle too short");
  a_pulse_len: assert property ($rose(STORE_BUSY_N_OE) |-> (STORE_BUSY_N_OE && !STORE_BUSY_N_OUT) [*3])
    else $error("save request pulse too short");
  a_busy_refuse: assert property (!STORE_BUSY_N_IN [*3] |=> !CMD_READY)
    else $error("ready while device busy");
  a_write_drive: assert property (!WRITE_STROBE_N |-> DQ_OE && !CHIP_SEL_N)
    else $error("write without data drive");
  a_read_float: assert property (!OUTPUT_DRIVE_N |-> !DQ_OE)
    else $error("host drives data in read");
  a_ce_write: assert property ($fell(WRITE_STROBE_N) |-> $fell(CHIP_SEL_N))
    else $error("write strobe fell before select");
endmodule // nvh_host_checker

//--- nvh_mem_model.sv
// Behavioural model of the non-volatile static memory
`timescale 1ns/1ps
module nvh_mem_model (
  input  wire        cs_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        ub_n,
  input  wire        lb_n,
  input  wire [17:0] addr,
  input  wire [15:0] dq_host,
  input  wire        busy_pin,
  output wire [15:0] dq_dev,
  output reg         busy_low
);
  reg [15:0] mem [0:15];
  reg [15:0] nv [0:15];
  reg [15:0] last = 16'h0000;
  reg        lock = 1'b1;
  reg        dirty = 1'b0;
  reg        wcyc = 1'b0;
  reg        op;
  reg [2:0]  idx = 3'h0;
  integer    i;
  wire       rd = !cs_n && we_n && !oe_n && !lock;
  wire [15:0] word = mem[addr[3:0]];
  // Released lanes flip instead of holding the last value
  assign dq_dev = {rd && !ub_n ? word[15:8] : ~last[15:8], rd && !lb_n ? word[7:0] : ~last[7:0]};
  initial begin
    busy_low = 1'b0;
    #100 lock = 1'b0;
  end
  always @(negedge rd) last = word;
  always @* if (!cs_n && !we_n && !lock) begin
    if (!ub_n) mem[addr[3:0]][15:8] = dq_host[15:8];
    if (!lb_n) mem[addr[3:0]][7:0] = dq_host[7:0];
    dirty = 1'b1;
    wcyc = 1'b1;
  end
  // Write flag avoids the strobe race at the end of a write cycle
  always @(posedge cs_n) begin
    if (wcyc) begin
      idx = 3'h0;
    end else if (!lock) begin
      if (idx == 3'h5 && addr[17:1] == 17'h00003) begin
        op = addr[0];
        lock = 1'b1;
        #90;
        for (i = 0; i < 16; i = i + 1)
          if (op) mem[i] = nv[i]; else nv[i] = mem[i];
        dirty = 1'b0;
        lock = 1'b0;
        idx = 3'h0;
      end else begin
        idx = (addr == {15'h0000, idx + 3'h1}) ? idx + 3'h1 : {2'h0, addr == 18'h00001};
      end
    end
    wcyc = 1'b0;
  end
  always @(negedge busy_pin) if (dirty && !busy_low) begin
    busy_low = 1'b1;
    #25 lock = 1'b1;
    #200;
    for (i = 0; i < 16; i = i + 1)
      nv[i] = mem[i];
    dirty = 1'b0;
    lock = 1'b0;
    busy_low = 1'b0;
    #500;
  end
endmodule // nvh_mem_model

//--- nvh_host_test.sv
// Self-checking testbench of the memory port host
`timescale 1ns/1ps
module nvh_host_test;
  logic        SYS_CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        CMD_VALID = 1'b0;
  logic [2:0]  CMD_OP = 3'h0;
  logic [17:0] CMD_ADDR = 18'h00000;
  logic [15:0] CMD_WDATA = 16'h0000;
  logic [1:0]  CMD_BYTE_EN = 2'h3;
  wire         CMD_READY, RSP_VALID, RSP_SUSPECT, CHIP_SEL_N, WRITE_STROBE_N, OUTPUT_DRIVE_N;
  wire         UPPER_BYTE_SEL_N, LOWER_BYTE_SEL_N, DQ_OE, STORE_BUSY_N_OUT, STORE_BUSY_N_OE;
  wire         busy_low;
  wire [15:0]  RSP_RDATA, DQ_OUT, dq_dev;
  wire [17:0]  MEM_ADDR;
  wire [15:0]  DQ_IN = DQ_OE ? DQ_OUT : dq_dev;
  wire         STORE_BUSY_N_IN = !(STORE_BUSY_N_OE && !STORE_BUSY_N_OUT) && !busy_low;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc;
  logic [15:0] rd;
  logic        sus;
  nvh_host #(.POWERUP_CYC(20), .CMD_PROC_CYC(10), .SAVE_CYC(10), .RESTORE_CYC(10)) i_nvh_host (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA), .CMD_BYTE_EN(CMD_BYTE_EN),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_SUSPECT(RSP_SUSPECT), .MEM_ADDR(MEM_ADDR), .CHIP_SEL_N(CHIP_SEL_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_DRIVE_N(OUTPUT_DRIVE_N),
    .UPPER_BYTE_SEL_N(UPPER_BYTE_SEL_N), .LOWER_BYTE_SEL_N(LOWER_BYTE_SEL_N),
    .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .STORE_BUSY_N_IN(STORE_BUSY_N_IN),
    .STORE_BUSY_N_OUT(STORE_BUSY_N_OUT), .STORE_BUSY_N_OE(STORE_BUSY_N_OE));
  nvh_mem_model i_nvh_mem_model (.cs_n(CHIP_SEL_N), .we_n(WRITE_STROBE_N),
    .oe_n(OUTPUT_DRIVE_N), .ub_n(UPPER_BYTE_SEL_N), .lb_n(LOWER_BYTE_SEL_N), .addr(MEM_ADDR),
    .dq_host(DQ_IN), .busy_pin(STORE_BUSY_N_IN), .dq_dev(dq_dev), .busy_low(busy_low));
  initial forever #2.5 SYS_CLK = ~SYS_CLK;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (exp !== got) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issues one command and, except for writes, waits for its response
  task automatic cmd(input logic [2:0] op, input logic [17:0] a, input logic [15:0] d,
                     input logic [1:0] be);
    int n = 0;
    while (CMD_READY !== 1'b1 && n < 4000) begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      $display("BAD ready wait expected 1 seen %b", CMD_READY);
    end
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ADDR = a;
    CMD_WDATA = d;
    CMD_BYTE_EN = be;
    @(posedge SYS_CLK);
    #1;
    CMD_VALID = 1'b0;
    cyc = 0;
    while (op != 3'h1 && RSP_VALID !== 1'b1 && cyc < 4000) begin
      @(posedge SYS_CLK);
      #1;
      cyc++;
    end
    if (cyc >= 4000) begin
      error_cnt++;
      $display("BAD response wait expected 1 seen %b", RSP_VALID);
    end
    rd = RSP_RDATA;
    sus = RSP_SUSPECT;
  endtask
  task automatic t_lanes;
    cmd(3'h1, 18'h00008, 16'h1234, 2'h3);
    cmd(3'h1, 18'h00008, 16'hAB99, 2'h2);
    cmd(3'h0, 18'h00008, 16'h0000, 2'h3);
    check("word", 16'hAB34, rd);
    check("read suspect", 16'h0000, {15'h0000, sus});
    cmd(3'h0, 18'h00008, 16'h0000, 2'h1);
    check("low lane", 16'h0034, {8'h00, rd[7:0]});
  endtask
  task automatic t_soft;
    cmd(3'h1, 18'h00009, 16'h5A5A, 2'h3);
    cmd(3'h2, 18'h00000, 16'h0000, 2'h3);
    check("suspect", 16'h0001, {15'h0000, sus});
    cmd(3'h1, 18'h00009, 16'hC3C3, 2'h3);
    cmd(3'h3, 18'h00000, 16'h0000, 2'h3);
    cmd(3'h0, 18'h00009, 16'h0000, 2'h3);
    check("restored", 16'h5A5A, rd);
  endtask
  task automatic t_hard;
    cmd(3'h1, 18'h0000A, 16'h0F0F, 2'h3);
    cmd(3'h4, 18'h00000, 16'h0000, 2'h3);
    check("save wait", 16'h0001, {15'h0000, cyc > 40});
    check("hw suspect", 16'h0000, {15'h0000, sus});
    cmd(3'h1, 18'h0000A, 16'hF0F0, 2'h3);
    cmd(3'h3, 18'h00000, 16'h0000, 2'h3);
    cmd(3'h0, 18'h0000A, 16'h0000, 2'h3);
    check("hw saved", 16'h0F0F, rd);
    cmd(3'h4, 18'h00000, 16'h0000, 2'h3);
    check("skip wait", 16'h0001, {15'h0000, cyc < 25});
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    #1;
    SRST = 1'b0;
    t_lanes;
    t_soft;
    t_hard;
    report_and_stop;
  end
endmodule // nvh_host_test
bind nvh_host nvh_host_checker #(.ADDR_W(ADDR_W)) i_nvh_host_checker (.SYS_CLK(SYS_CLK),
  .SRST(SRST), .CMD_READY(CMD_READY), .MEM_ADDR(MEM_ADDR), .CHIP_SEL_N(CHIP_SEL_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_DRIVE_N(OUTPUT_DRIVE_N), .DQ_OE(DQ_OE),
  .STORE_BUSY_N_IN(STORE_BUSY_N_IN), .STORE_BUSY_N_OUT(STORE_BUSY_N_OUT),
  .STORE_BUSY_N_OE(STORE_BUSY_N_OE));
